// ==== pkg/ima_irq_params.svh ====
// Register offsets, field positions and reset values of the interrupt status unit
`ifndef IMA_IRQ_PARAMS_SVH
`define IMA_IRQ_PARAMS_SVH
`define TEST_CONTROL_ONE_ADDR       10'h04E
`define TEST_CONTROL_TWO_ADDR       10'h0DA
`define GROUP_OVF_IRQ_ENABLE_ADDR   10'h204
`define GENERAL_STATUS_ADDR         10'h206
`define UNI_LINK_OVF_STATUS_ADDR    10'h208
`define GROUP_CNT_OVF_STATUS_ADDR   10'h210
`define MASTER_IRQ_ENABLE_ADDR      10'h218
`define LINK_IRQ_ENABLE_ADDR        10'h219
`define LINK_IRQ_STATUS_ADDR        10'h222
`define LINE_CNT_OVF_STATUS_ADDR    10'h22A
`define MASTER_IRQ_STATUS_ADDR      10'h232
`define GROUP_OVF_SUMMARY_ADDR      10'h235
`define NUM_LINKS                   8
`define NUM_GROUPS                  4
// Revision value is arbitrary
`define DEVICE_REVISION             4'h6
`define REG_RESET                   8'h00
`define LINK_SUMMARY_BIT            7
`define LINK_GROUP_EVENT_BIT        6
`define LINK_COUNTER_OVF_BIT        0
`endif

// ==== pkg/ima_irq_pkg.sv ====
// Types shared by the interrupt status unit
package ima_irq_pkg;
   // Host register port request
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [9:0] addr;
      logic [7:0] wdata;
   } host_req_t;
   // Per-link hardware events
   typedef struct packed {
      logic cell_change;
      logic control_cell_violation_flag;
      logic delay_sync_loss_flag;
      logic frame_loss_flag;
      logic cell_delineation_loss_flag;
      logic counter_ovf;
   } link_events_t;
endpackage

// ==== src/ima_phy_interrupt_status_unit.sv ====
// Interrupt aggregation, masking and status registers of the octal link device
//
// Summary of operation
// - Master status shows per-link pending requests
// - Writes to master status are ignored
// - Master status unlatched; enable acts at once
// - Pin low when status and enable set
// - Link0 bit7 summarises group overflow sources
// - Link0 bit6 group ready/frame event, write-0 clears
// - Bit5 control cell with changes stored
// - Bits4-1 violation, delay, frame, delineation flags
// - Bit0 counter overflow, cleared by counter access
// - Per-link eight-bit enable register
// - Group overflow status one bit per group
// - Group overflow enable, bits 7:4 zero
// - Per-group fifo and input counter overflows
// - UNI link overflow bits, write-0 clears
// - Line counter overflow bit mapping
// - General status revision field bits 7:4
// - Output/input clock loss latched, write-0 clears
// - Tx fifo overflow; no free cell latched
`timescale 1ns/1ns
`default_nettype none
`include "ima_irq_params.svh"
module ima_phy_interrupt_status_unit
   import ima_irq_pkg::*;
(
   // Clock and reset
   input  wire logic                   i_sys_clk,
   input  wire logic                   i_nrst,
   // Register port, same clock
   input  wire host_req_t              i_host,
   output logic [7:0]                  o_rdata,
   // Link events, one-cycle pulses
   input  wire link_events_t [7:0]     i_link_ev,
   input  wire logic [7:0][4:0]        i_uni_ovf_ev,
   input  wire logic [7:0][7:0]        i_line_ovf_ev,
   input  wire logic [7:0]             i_link_cnt_access,
   // Group events
   input  wire logic [3:0][4:0]        i_group_ovf_ev,
   input  wire logic                   i_group_event,
   // General events
   input  wire logic                   i_utopia_out_clk_loss,
   input  wire logic                   i_utopia_in_clk_loss,
   input  wire logic                   i_tx_fifo_ovf,
   input  wire logic                   i_no_free_cell,
   // Test register outputs
   output logic                        o_link_add_mode,
   output logic [1:0]                  o_link_add_group,
   // Interrupt pin, active low
   output logic                        o_irq_n
);
   // ***************************************************************
   // Reset synchroniser
   // ***************************************************************
   logic       rst_meta;
   logic       rst_n;
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ***************************************************************
   // Storage
   // ***************************************************************
   logic [7:0]      master_en;
   logic [7:0][7:0] link_en;
   logic [7:0][5:1] link_flags;
   logic [7:0]      link_cnt_ovf;
   logic            group_event_flag;
   logic [3:0]      group_ovf_en;
   logic [3:0][4:0] group_ovf;
   logic [7:0][4:0] uni_ovf;
   logic [7:0][7:0] line_ovf;
   logic [3:0]      gen_flags;
   logic [7:0]      test_one;
   logic [7:0]      test_two;
   logic [3:0]      group_summary;
   logic            group_pending;
   logic [7:0][7:0] link_status;
   logic [7:0]      master_status;

   wire logic wr = i_host.wr;
   wire logic [9:0] ad = i_host.addr;
   wire logic [7:0] wd = i_host.wdata;

   // Write-0 clears, event sets; set has priority
   function automatic logic [7:0] w0c(input logic [7:0] cur, input logic [7:0] ev,
                                      input logic hit);
      w0c = ((hit ? (cur & wd) : cur) | ev);
   endfunction

   // ***************************************************************
   // Address decode
   // ***************************************************************
   // One-hot selects keep the read mux free of priority chains
   logic            sel_master_stat;
   logic            sel_master_en;
   logic            sel_group_en;
   logic            sel_group_sum;
   logic            sel_general;
   logic            sel_test_one;
   logic            sel_test_two;
   logic [7:0]      sel_link_stat;
   logic [7:0]      sel_link_en;
   logic [7:0]      sel_uni;
   logic [7:0]      sel_line;
   logic [3:0]      sel_group_ovf;

   assign sel_master_stat = (ad == `MASTER_IRQ_STATUS_ADDR);
   assign sel_master_en   = (ad == `MASTER_IRQ_ENABLE_ADDR);
   assign sel_group_en    = (ad == `GROUP_OVF_IRQ_ENABLE_ADDR);
   assign sel_group_sum   = (ad == `GROUP_OVF_SUMMARY_ADDR);
   assign sel_general     = (ad == `GENERAL_STATUS_ADDR);
   assign sel_test_one    = (ad == `TEST_CONTROL_ONE_ADDR);
   assign sel_test_two    = (ad == `TEST_CONTROL_TWO_ADDR);

   genvar s;
   generate
      for (s = 0; s < `NUM_LINKS; s++) begin : g_link_sel
         assign sel_link_stat[s] = (ad == `LINK_IRQ_STATUS_ADDR + 10'(s));
         assign sel_link_en[s]   = (ad == `LINK_IRQ_ENABLE_ADDR + 10'(s));
         assign sel_uni[s]       = (ad == `UNI_LINK_OVF_STATUS_ADDR + 10'(s));
         assign sel_line[s]      = (ad == `LINE_CNT_OVF_STATUS_ADDR + 10'(s));
      end
      for (s = 0; s < `NUM_GROUPS; s++) begin : g_group_sel
         assign sel_group_ovf[s] = (ad == `GROUP_CNT_OVF_STATUS_ADDR + 10'(s));
      end
   endgenerate

   // ***************************************************************
   // Control registers
   // ***************************************************************
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         master_en <= `REG_RESET;
      end else if (wr && sel_master_en) begin
         master_en <= wd;
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         group_ovf_en <= 4'h0;
      end else if (wr && sel_group_en) begin
         group_ovf_en <= wd[3:0];
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         test_one <= `REG_RESET;
      end else if (wr && sel_test_one) begin
         test_one <= wd;
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         test_two <= `REG_RESET;
      end else if (wr && sel_test_two) begin
         test_two <= wd;
      end
   end
   // Link addition control taken from test two
   assign o_link_add_mode  = test_two[3];
   assign o_link_add_group = test_two[1:0];

   // ***************************************************************
   // Per-link registers
   // ***************************************************************
   genvar l;
   generate
      for (l = 0; l < `NUM_LINKS; l++) begin : g_link
         logic [7:0] ev;
         logic [7:0] next_flags;
         logic [7:0] next_uni;
         logic [7:0] next_line;
         logic [7:0] masked;
         assign ev = {2'b00, i_link_ev[l].cell_change,
                      i_link_ev[l].control_cell_violation_flag,
                      i_link_ev[l].delay_sync_loss_flag,
                      i_link_ev[l].frame_loss_flag,
                      i_link_ev[l].cell_delineation_loss_flag, 1'b0};
         // Process, not assign, so the merge also follows the write data
         always_comb begin
            next_flags = w0c({2'b00, link_flags[l], 1'b0}, ev,
                             wr && sel_link_stat[l]);
            next_uni   = w0c({3'b000, uni_ovf[l]}, {3'b000, i_uni_ovf_ev[l]},
                             wr && sel_uni[l]);
            next_line  = w0c(line_ovf[l], i_line_ovf_ev[l],
                             wr && sel_line[l]);
         end

         always_ff @(posedge i_sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               link_en[l] <= `REG_RESET;
            end else if (wr && sel_link_en[l]) begin
               link_en[l] <= wd;
            end
         end

         always_ff @(posedge i_sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               link_flags[l] <= 5'h00;
            end else begin
               link_flags[l] <= next_flags[5:1];
            end
         end

         // Cleared only by counter access
         always_ff @(posedge i_sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               link_cnt_ovf[l] <= 1'b0;
            end else begin
               link_cnt_ovf[l] <= i_link_ev[l].counter_ovf |
                  (link_cnt_ovf[l] & ~i_link_cnt_access[l]);
            end
         end

         always_ff @(posedge i_sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               uni_ovf[l] <= 5'h00;
            end else begin
               uni_ovf[l] <= next_uni[4:0];
            end
         end

         always_ff @(posedge i_sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               line_ovf[l] <= `REG_RESET;
            end else begin
               line_ovf[l] <= next_line;
            end
         end

         assign link_status[l] = {
            (l == 0) ? group_pending : 1'b0,
            (l == 0) ? group_event_flag : 1'b0,
            link_flags[l], link_cnt_ovf[l]};
         assign masked = link_status[l] & link_en[l];
         assign master_status[l] = |masked;
      end
   endgenerate

   // ***************************************************************
   // Group registers
   // ***************************************************************
   genvar g;
   generate
      for (g = 0; g < `NUM_GROUPS; g++) begin : g_grp
         logic [7:0] next_grp;
         always_comb begin
            next_grp = w0c({3'b000, group_ovf[g]}, {3'b000, i_group_ovf_ev[g]},
                           wr && sel_group_ovf[g]);
         end

         always_ff @(posedge i_sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               group_ovf[g] <= 5'h00;
            end else begin
               group_ovf[g] <= next_grp[4:0];
            end
         end
         // Any counter or fifo overflow of the group
         assign group_summary[g] = |group_ovf[g];
      end
   endgenerate
   // Clears when the group sources are serviced or their enables are cleared
   assign group_pending = |(group_summary & group_ovf_en);

   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         group_event_flag <= 1'b0;
      end else begin
         group_event_flag <= i_group_event |
            (group_event_flag & ~(wr && ad == `LINK_IRQ_STATUS_ADDR &&
             !wd[`LINK_GROUP_EVENT_BIT]));
      end
   end

   // ***************************************************************
   // General status
   // ***************************************************************
   logic [3:0] gen_ev;
   logic       gen_hit;
   assign gen_ev  = {i_utopia_out_clk_loss, i_utopia_in_clk_loss,
                     i_tx_fifo_ovf, i_no_free_cell};
   assign gen_hit = wr && sel_general;

   // Tx fifo overflow also taken as write-0 clear for symmetry
   genvar f;
   generate
      for (f = 0; f < 4; f++) begin : g_gen
         always_ff @(posedge i_sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               gen_flags[f] <= 1'b0;
            end else begin
               // Set beats a clearing write in the same cycle
               gen_flags[f] <= gen_ev[f] |
                  (gen_flags[f] & ~(gen_hit & ~wd[f]));
            end
         end
      end
   endgenerate

   // ***************************************************************
   // Interrupt pin and read data
   // ***************************************************************
   // Combinational from flags so enable changes act at once
   logic [7:0] irq_request;
   assign irq_request = master_status & master_en;
   assign o_irq_n     = ~|irq_request;

   // ***************************************************************
   // Read data
   // ***************************************************************
   logic [7:0] next_rdata;
   logic [7:0] link_rd;
   logic [7:0] group_rd;

   // Per-link and per-group words merge over one-hot selects
   always_comb begin
      link_rd  = `REG_RESET;
      group_rd = `REG_RESET;
      for (int i = 0; i < `NUM_LINKS; i++) begin
         if (sel_link_stat[i]) begin
            link_rd = link_rd | link_status[i];
         end
         if (sel_link_en[i]) begin
            link_rd = link_rd | link_en[i];
         end
         if (sel_uni[i]) begin
            link_rd = link_rd | {3'b000, uni_ovf[i]};
         end
         if (sel_line[i]) begin
            link_rd = link_rd | line_ovf[i];
         end
      end
      for (int j = 0; j < `NUM_GROUPS; j++) begin
         if (sel_group_ovf[j]) begin
            group_rd = group_rd | {3'b000, group_ovf[j]};
         end
      end
   end

   // Unmapped addresses fall through to zero
   always_comb begin
      next_rdata = link_rd | group_rd;
      if (sel_master_stat) begin
         next_rdata = master_status;
      end
      if (sel_master_en) begin
         next_rdata = master_en;
      end
      if (sel_group_en) begin
         next_rdata = {4'h0, group_ovf_en};
      end
      if (sel_group_sum) begin
         next_rdata = {4'h0, group_summary};
      end
      if (sel_general) begin
         next_rdata = {`DEVICE_REVISION, gen_flags};
      end
      // Test registers read back inverted, not the written value
      if (sel_test_one) begin
         next_rdata = ~test_one;
      end
      if (sel_test_two) begin
         next_rdata = ~test_two;
      end
   end

   // Read data holds between reads
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_rdata <= `REG_RESET;
      end else if (i_host.rd) begin
         o_rdata <= next_rdata;
      end
   end
endmodule
`default_nettype wire

// ==== test/ima_irq_asserts.sv ====
// Port-level checks of the interrupt status unit
`timescale 1ns/1ns
`default_nettype none
`include "ima_irq_params.svh"
module ima_irq_asserts
   import ima_irq_pkg::*;
(
   // Clock, reset, host
   input wire logic              i_sys_clk,
   input wire logic              i_nrst,
   input wire host_req_t         i_host,
   input wire logic [7:0]        o_rdata,
   // Events
   input wire link_events_t [7:0] i_link_ev,
   input wire logic [7:0][4:0]   i_uni_ovf_ev,
   input wire logic [7:0][7:0]   i_line_ovf_ev,
   input wire logic [7:0]        i_link_cnt_access,
   input wire logic [3:0][4:0]   i_group_ovf_ev,
   input wire logic              i_group_event,
   input wire logic              i_utopia_out_clk_loss,
   input wire logic              i_utopia_in_clk_loss,
   input wire logic              i_tx_fifo_ovf,
   input wire logic              i_no_free_cell,
   // Outputs
   input wire logic              o_link_add_mode,
   input wire logic [1:0]        o_link_add_group,
   input wire logic              o_irq_n
);
   // ****
   // Helpers
   // ****
   logic       quiet;
   logic       rdo;
   logic [9:0] a;
   logic [7:0] wd;
   assign quiet = ~|{i_link_ev, i_uni_ovf_ev, i_line_ovf_ev, i_link_cnt_access,
                     i_group_ovf_ev, i_group_event, i_utopia_out_clk_loss,
                     i_utopia_in_clk_loss, i_tx_fifo_ovf, i_no_free_cell};
   assign rdo = i_host.rd & ~i_host.wr;
   assign a = i_host.addr;
   assign wd = i_host.wdata;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   // Pin moves only on an event or a write
   property p_irq_hold; quiet && !i_host.wr |=> $stable(o_irq_n); endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq moved");
   property p_ms_write;
      quiet && i_host.wr && a == `MASTER_IRQ_STATUS_ADDR |=> $stable(o_irq_n);
   endproperty
   a_ms_write: assert property (p_ms_write) else $error("status write acted");
   property p_en_off;
      i_host.wr && a == `MASTER_IRQ_ENABLE_ADDR && wd == 8'h00 |=> o_irq_n;
   endproperty
   a_en_off: assert property (p_en_off) else $error("irq with no enable");
   property p_add;
      i_host.wr && a == `TEST_CONTROL_TWO_ADDR
      |=> {o_link_add_mode, o_link_add_group} == {$past(wd[3]), $past(wd[1:0])};
   endproperty
   a_add: assert property (p_add) else $error("link add outputs");
   property p_rev;
      rdo && a == `GENERAL_STATUS_ADDR |=> o_rdata[7:4] == `DEVICE_REVISION;
   endproperty
   a_rev: assert property (p_rev) else $error("revision field");
   property p_gen_hi; rdo && a == `GROUP_OVF_IRQ_ENABLE_ADDR |=> o_rdata[7:4] == 4'h0; endproperty
   a_gen_hi: assert property (p_gen_hi) else $error("enable upper bits");
   property p_grp_hi; rdo && a inside {[10'h210:10'h213]} |=> o_rdata[7:5] == 3'h0; endproperty
   a_grp_hi: assert property (p_grp_hi) else $error("group ovf upper bits");
   property p_hold; !i_host.rd |=> $stable(o_rdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_clk_loss;
      i_utopia_out_clk_loss ##1 (rdo && a == `GENERAL_STATUS_ADDR) |=> o_rdata[3];
   endproperty
   a_clk_loss: assert property (p_clk_loss) else $error("clock loss lost");
   c_irq: cover property (!o_irq_n);
   c_add: cover property ($rose(o_link_add_mode));
   c_loss: cover property (p_clk_loss);
endmodule
bind ima_phy_interrupt_status_unit ima_irq_asserts ima_irq_asserts_inst (.i_sys_clk, .i_nrst,
   .i_host, .o_rdata, .i_link_ev, .i_uni_ovf_ev, .i_line_ovf_ev, .i_link_cnt_access,
   .i_group_ovf_ev, .i_group_event, .i_utopia_out_clk_loss, .i_utopia_in_clk_loss,
   .i_tx_fifo_ovf, .i_no_free_cell, .o_link_add_mode, .o_link_add_group, .o_irq_n);
`default_nettype wire

// ==== test/ima_phy_interrupt_status_unit_bench.sv ====
// Directed bench for the interrupt status unit
`timescale 1ns/1ns
`default_nettype none
`include "ima_irq_params.svh"
module ima_phy_interrupt_status_unit_bench import ima_irq_pkg::*;;
   // ****
   // Stimulus and checks
   // ****
   logic               clk = 0, nrst = 0, gev = 0, ock = 0, ick = 0, tfo = 0, nfc = 0;
   host_req_t          host = '0;
   link_events_t [7:0] lev = '0;
   logic [7:0][4:0]    uni = '0;
   logic [7:0][7:0]    line = '0;
   logic [3:0][4:0]    gov = '0;
   logic [7:0]         acc = '0, rdata;
   logic [1:0]         add_g;
   logic               add_m, irq_n;
   int                 err_count = 0, checks_done = 0, cyc = 0;
   ima_phy_interrupt_status_unit ima_phy_interrupt_status_unit_inst (.i_sys_clk(clk),
      .i_nrst(nrst), .i_host(host), .o_rdata(rdata), .i_link_ev(lev), .i_uni_ovf_ev(uni),
      .i_line_ovf_ev(line), .i_link_cnt_access(acc), .i_group_ovf_ev(gov),
      .i_group_event(gev), .i_utopia_out_clk_loss(ock), .i_utopia_in_clk_loss(ick),
      .i_tx_fifo_ovf(tfo), .i_no_free_cell(nfc), .o_link_add_mode(add_m),
      .o_link_add_group(add_g), .o_irq_n(irq_n));
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count++;
         finish_test;
      end
   end
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [9:0] a, input logic [7:0] d);
      @(negedge clk) host.wr = 1; host.addr = a; host.wdata = d;
      @(negedge clk) host.wr = 0;
   endtask
   task rd(input logic [9:0] a, input logic [7:0] e);
      @(negedge clk) host.rd = 1; host.addr = a;
      @(negedge clk) host.rd = 0;
      chk(rdata, e);
   endtask
   task t_reset;
      logic [9:0] z[8] = '{10'h232, 10'h218, 10'h219, 10'h222, 10'h210, 10'h208, 10'h22A, 10'h204};
      for (int i = 0; i < 8; i++) rd(z[i], 8'h00);
      rd(10'h206, {`DEVICE_REVISION, 4'h0});
      rd(10'h300, 8'h00);
      $display("reset test done");
   endtask
   task t_link;
      wr(10'h21C, 8'hFF);
      wr(10'h218, 8'h08);
      @(negedge clk) lev[3] = '1;
      @(negedge clk) lev[3] = '0;
      rd(10'h225, 8'h3F);
      rd(10'h232, 8'h08);
      chk({7'h0, irq_n}, 8'h00);
      wr(10'h218, 8'h00);
      chk({7'h0, irq_n}, 8'h01);
      wr(10'h232, 8'h00);
      rd(10'h232, 8'h08);
      wr(10'h225, 8'hFB);
      rd(10'h225, 8'h3B);
      @(negedge clk) acc[3] = 1;
      @(negedge clk) acc[3] = 0;
      rd(10'h225, 8'h3A);
      wr(10'h21C, 8'h01);
      rd(10'h232, 8'h00);
      wr(10'h225, 8'h00);
      rd(10'h225, 8'h00);
      $display("link test done");
   endtask
   task t_group;
      @(negedge clk) gov[2][4] = 1; gev = 1;
      @(negedge clk) gov[2][4] = 0; gev = 0;
      rd(10'h212, 8'h10);
      rd(10'h235, 8'h04);
      rd(10'h222, 8'h40);
      rd(10'h223, 8'h00);
      wr(10'h204, 8'hFF);
      rd(10'h204, 8'h0F);
      wr(10'h222, 8'h00);
      rd(10'h222, 8'h80);
      wr(10'h212, 8'h00);
      rd(10'h222, 8'h00);
      $display("group test done");
   endtask
   task t_misc;
      @(negedge clk) {ock, ick, tfo, nfc} = 4'hF; host.wr = 1; host.addr = 10'h206; host.wdata = 0;
      @(negedge clk) {ock, ick, tfo, nfc} = 4'h0; host.wr = 0; host.rd = 1;
      @(negedge clk) host.rd = 0;
      chk(rdata, {`DEVICE_REVISION, 4'hF});
      wr(10'h206, 8'h00);
      rd(10'h206, {`DEVICE_REVISION, 4'h0});
      @(negedge clk) uni[5][3] = 1; line[7][7] = 1;
      @(negedge clk) uni[5][3] = 0; line[7][7] = 0;
      rd(10'h20D, 8'h08);
      rd(10'h231, 8'h80);
      wr(10'h20D, 8'h00);
      rd(10'h20D, 8'h00);
      wr(10'h04E, 8'h60);
      rd(10'h04E, 8'h9F);
      wr(10'h0DA, 8'h4B);
      chk({5'h0, add_m, add_g}, 8'h07);
      wr(10'h0DA, 8'h40);
      chk({5'h0, add_m, add_g}, 8'h00);
      $display("misc test done");
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge clk);
      nrst = 1;
      repeat (3) @(negedge clk);
      t_reset;
      t_link;
      t_group;
      t_misc;
      finish_test;
   end
endmodule
`default_nettype wire
